// [wdt_pkg.sv]
// Package with constants and a carrier type for the watchdog block.
package wdt_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int unsigned SYS_CLK_HZ      = 20_000_000;
  localparam int unsigned WDT_PERIOD_US   = 18_000;
  localparam int unsigned WDT_PERIOD_CYC  =
    (SYS_CLK_HZ / 1_000_000) * WDT_PERIOD_US;
  localparam int unsigned WDT_CNT_W       = 19;

  // ----------------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [3:0] OPTION_ADDR   = 4'h0;
  localparam logic [3:0] STATUS_ADDR   = 4'h4;
  localparam logic [3:0] CONTROL_ADDR  = 4'h8;
  localparam logic [3:0] CONFIG_ADDR   = 4'hC;

  // ----------------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------------
  localparam int unsigned PSA_BIT        = 3;
  localparam int unsigned PS_LSB         = 0;
  localparam int unsigned TO_BIT         = 0;
  localparam int unsigned SLEEP_ST_BIT   = 1;
  localparam int unsigned CLR_BIT        = 0;
  localparam int unsigned SLEEP_BIT      = 1;
  localparam int unsigned WATCHDOG_ENABLE_FUSE_BIT       = 2;
  localparam logic [7:0]  OPTION_RST     = 8'hFF;
  localparam logic [1:0]  RESP_OKAY      = 2'b00;
  localparam logic [1:0]  RESP_SLVERR    = 2'b10;

  typedef struct packed {
    logic       assign_sel;
    logic [2:0] ratio_sel;
  } prescale_cfg_t;

endpackage : wdt_pkg

// [wdt_core.sv]
// Watchdog counter with shared postscaler.
`timescale 1ns/100ps
module wdt_core
  import wdt_pkg::*;
#(
  parameter int unsigned PERIOD_CYC = WDT_PERIOD_CYC
)
(
  // Clock and reset
  input  wire logic          sys_clk_i,
  input  wire logic          rst_n_i,
  // Control
  input  wire logic          enable_i,
  input  wire logic          clear_i,
  input  wire prescale_cfg_t cfg_i,
  // Result
  output logic               expire_o
);

  logic [WDT_CNT_W-1:0] watchdog_counter_r;
  logic [7:0]           post_r;
  logic                 tick;
  logic                 post_hit;

  assign tick = (watchdog_counter_r == WDT_CNT_W'(PERIOD_CYC - 1));
  // Ratio is two to the power of the select value.
  assign post_hit = (post_r == ((8'h01 << cfg_i.ratio_sel) - 8'h01));

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      watchdog_counter_r <= '0;
    else if (!enable_i || clear_i || tick)
      watchdog_counter_r <= '0;
    else
      watchdog_counter_r <= watchdog_counter_r + 1'b1;
  end

  // When the prescaler serves Timer0 the watchdog sees no scaling.
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      post_r <= '0;
    else if (!enable_i || clear_i || !cfg_i.assign_sel)
      post_r <= '0;
    else if (tick)
      post_r <= post_hit ? 8'h00 : post_r + 8'h01;
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      expire_o <= 1'b0;
    else
      expire_o <= enable_i && !clear_i && tick &&
                  (!cfg_i.assign_sel || post_hit);
  end

endmodule : wdt_core

// [wdt_top.sv]
// Watchdog timer top level with AXI4-Lite register slave.
//
// Contract
// - Watchdog counts on its own free-running clock; here sys_clk_i stands in for it.
// - Expiry while awake causes full device reset.
// - Expiry while asleep wakes device, no reset.
// - Cleared enable fuse keeps watchdog disabled.
// - Unscaled expiry period nominally 18 ms.
// - Software assigns prescaler, ratio up to 1:128.
// - Clear or sleep instruction resets counter, postscaler.
// - Every expiry clears active-low time-out flag.
// - One prescaler serves Timer0 or watchdog only.
// - Option low four bits select assignment, ratio.
// - Config word bit 2 enables the watchdog.
`timescale 1ns/100ps
module wdt_top
  import wdt_pkg::*;
#(
  // Expiry count; only a bench shortens it, to keep its runs brief.
  parameter int unsigned PERIOD_CYC = WDT_PERIOD_CYC
)
(
  // Clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        rstn_i,
  // Configuration word
  input  wire logic [13:0] config_word_i,
  // AXI4-Lite write address
  input  wire logic        awvalid_i,
  output logic             awready_o,
  input  wire logic [3:0]  awaddr_i,
  // AXI4-Lite write data
  input  wire logic        wvalid_i,
  output logic             wready_o,
  input  wire logic [31:0] wdata_i,
  input  wire logic [3:0]  wstrb_i,
  // AXI4-Lite write response
  output logic             bvalid_o,
  input  wire logic        bready_i,
  output logic [1:0]       bresp_o,
  // AXI4-Lite read address
  input  wire logic        arvalid_i,
  output logic             arready_o,
  input  wire logic [3:0]  araddr_i,
  // AXI4-Lite read data
  output logic             rvalid_o,
  input  wire logic        rready_i,
  output logic [31:0]      rdata_o,
  output logic [1:0]       rresp_o,
  // Device effects
  output logic             device_reset_o,
  output logic             wake_o,
  output logic             sleeping_o
);

  // ----------------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------------
  logic [1:0] rst_sync_r;
  logic       rst_n;

  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      rst_sync_r <= 2'b00;
    else
      rst_sync_r <= {rst_sync_r[0], 1'b1};
  end
  assign rst_n = rst_sync_r[1];

  // ----------------------------------------------------------------------
  // Fuse capture
  // ----------------------------------------------------------------------
  // The fuse is static, so it is sampled once each clock after reset.
  logic fuse_s1_r, fuse_s2_r, fuse_s3_r, watchdog_enable_fuse_r;

  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fuse_s1_r              <= 1'b0;
      fuse_s2_r              <= 1'b0;
      fuse_s3_r              <= 1'b0;
      watchdog_enable_fuse_r <= 1'b0;
    end
    else
    begin
      fuse_s1_r <= config_word_i[WATCHDOG_ENABLE_FUSE_BIT];
      fuse_s2_r <= fuse_s1_r;
      fuse_s3_r <= fuse_s2_r;
      if (fuse_s2_r == fuse_s3_r)
        watchdog_enable_fuse_r <= fuse_s3_r;
    end
  end

  // ----------------------------------------------------------------------
  // Write channel
  // ----------------------------------------------------------------------
  logic [7:0] option_r;
  logic       timeout_flag_n_r;
  logic       sleep_r;
  logic       aw_held_r, w_held_r;
  logic [3:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic       wr_go;
  logic       clr_pulse_r;
  logic       expire;

  assign wr_go = aw_held_r && w_held_r && !bvalid_o;

  // Ready is registered; it mirrors an empty slot and no pending response.
  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      awready_o <= 1'b1;
      wready_o  <= 1'b1;
    end
    else if (wr_go)
    begin
      awready_o <= 1'b0;
      wready_o  <= 1'b0;
    end
    else if (bvalid_o && bready_i)
    begin
      awready_o <= 1'b1;
      wready_o  <= 1'b1;
    end
    else
    begin
      if (awvalid_i && awready_o)
        awready_o <= 1'b0;
      if (wvalid_i && wready_o)
        wready_o <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      aw_addr_r <= '0;
      w_data_r  <= '0;
      w_strb_r  <= '0;
      bvalid_o  <= 1'b0;
      bresp_o   <= RESP_OKAY;
    end
    else
    begin
      if (awvalid_i && awready_o)
      begin
        aw_held_r <= 1'b1;
        aw_addr_r <= awaddr_i;
      end
      if (wvalid_i && wready_o)
      begin
        w_held_r <= 1'b1;
        w_data_r <= wdata_i;
        w_strb_r <= wstrb_i;
      end
      if (wr_go)
      begin
        aw_held_r <= 1'b0;
        w_held_r  <= 1'b0;
        bvalid_o  <= 1'b1;
        bresp_o   <= (aw_addr_r == OPTION_ADDR || aw_addr_r == CONTROL_ADDR)
                     ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bvalid_o && bready_i)
        bvalid_o <= 1'b0;
    end
  end

  // Option register; only the low byte lane is implemented.
  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      option_r <= OPTION_RST;
    else if (wr_go && aw_addr_r == OPTION_ADDR && w_strb_r[0])
      option_r <= w_data_r[7:0];
  end

  // Control writes stand for the clear and sleep instructions.
  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      clr_pulse_r <= 1'b0;
    else
      clr_pulse_r <= wr_go && aw_addr_r == CONTROL_ADDR && w_strb_r[0] &&
                     (w_data_r[CLR_BIT] || w_data_r[SLEEP_BIT]);
  end

  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      sleep_r <= 1'b0;
    else if (expire)
      sleep_r <= 1'b0;
    else if (wr_go && aw_addr_r == CONTROL_ADDR && w_strb_r[0] &&
             w_data_r[SLEEP_BIT])
      sleep_r <= 1'b1;
  end
  assign sleeping_o = sleep_r;

  // ----------------------------------------------------------------------
  // Watchdog core
  // ----------------------------------------------------------------------
  prescale_cfg_t cfg;
  assign cfg.assign_sel = option_r[PSA_BIT];
  assign cfg.ratio_sel  = option_r[PS_LSB +: 3];

  // The system clock stands in for the free-running watchdog oscillator.
  wdt_core #(
    .PERIOD_CYC (PERIOD_CYC)
  ) u_core (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n),
    .enable_i  (watchdog_enable_fuse_r),
    .clear_i   (clr_pulse_r),
    .cfg_i     (cfg),
    .expire_o  (expire)
  );

  // ----------------------------------------------------------------------
  // Expiry effects
  // ----------------------------------------------------------------------
  // The flag survives the watchdog reset it reports; only rstn or a clear or sleep write sets it again.
  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      timeout_flag_n_r <= 1'b1;
    else if (expire)
      timeout_flag_n_r <= 1'b0;
    else if (clr_pulse_r)
      timeout_flag_n_r <= 1'b1;
  end

  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      device_reset_o <= 1'b0;
      wake_o         <= 1'b0;
    end
    else
    begin
      device_reset_o <= expire && !sleep_r;
      wake_o         <= expire && sleep_r;
    end
  end

  // ----------------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      arready_o <= 1'b1;
      rvalid_o  <= 1'b0;
      rdata_o   <= '0;
      rresp_o   <= RESP_OKAY;
    end
    else if (arvalid_i && arready_o)
    begin
      arready_o <= 1'b0;
      rvalid_o  <= 1'b1;
      rresp_o   <= RESP_OKAY;
      unique case (araddr_i)
        OPTION_ADDR:  rdata_o <= {24'h00_0000, option_r};
        STATUS_ADDR:  rdata_o <= {30'h0000_0000, sleep_r, timeout_flag_n_r};
        CONTROL_ADDR: rdata_o <= 32'h0000_0000;
        CONFIG_ADDR:  rdata_o <= {31'h0000_0000, watchdog_enable_fuse_r};
        default:
        begin
          rdata_o <= 32'h0000_0000;
          rresp_o <= RESP_SLVERR;
        end
      endcase
    end
    else if (rvalid_o && rready_i)
    begin
      arready_o <= 1'b1;
      rvalid_o  <= 1'b0;
    end
  end

endmodule : wdt_top

// [wdt_top_checker.sv]
// Concurrent checks on the watchdog top-level ports.
`timescale 1ns/100ps
module wdt_top_checker
(
  // Clock, reset and fuse
  input wire logic        sys_clk_i,
  input wire logic        rstn_i,
  input wire logic [13:0] config_word_i,
  // Register bus
  input wire logic        arvalid_i,
  input wire logic        arready_o,
  input wire logic        rvalid_o,
  input wire logic        rready_i,
  input wire logic [31:0] rdata_o,
  input wire logic        bvalid_o,
  input wire logic        bready_i,
  // Device effects
  input wire logic        device_reset_o,
  input wire logic        wake_o,
  input wire logic        sleeping_o
);
  // --------------------------------------------------------------------
  // Properties
  // --------------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rstn_i);

  property p_rst_pulse;
    device_reset_o |=> !device_reset_o;
  endproperty
  a_rst_pulse: assert property (p_rst_pulse)
    else $error("device reset longer than one cycle");
  property p_rst_awake;
    device_reset_o |-> !$past(sleeping_o);
  endproperty
  a_rst_awake: assert property (p_rst_awake)
    else $error("device reset raised while asleep");
  property p_wake_pulse;
    wake_o |=> !wake_o;
  endproperty
  a_wake_pulse: assert property (p_wake_pulse)
    else $error("wake longer than one cycle");
  property p_wake_asleep;
    wake_o |-> $past(sleeping_o) && !device_reset_o;
  endproperty
  a_wake_asleep: assert property (p_wake_asleep)
    else $error("wake raised while awake");
  property p_fuse_off;
    !config_word_i[2] |-> !device_reset_o && !wake_o;
  endproperty
  a_fuse_off: assert property (p_fuse_off)
    else $error("expiry with fuse cleared");
  property p_rd_lat;
    arvalid_i && arready_o |=> rvalid_o;
  endproperty
  a_rd_lat: assert property (p_rd_lat)
    else $error("read answer late");
  property p_rd_hold;
    rvalid_o && !rready_i |=> rvalid_o && $stable(rdata_o);
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data dropped");
  property p_wr_hold;
    bvalid_o && !bready_i |=> bvalid_o;
  endproperty
  a_wr_hold: assert property (p_wr_hold)
    else $error("write response dropped");
endmodule : wdt_top_checker

// [tb_watchdog_timer_with_postscaler.sv]
// Self-checking testbench for the watchdog top level.
`timescale 1ns/100ps
module tb_watchdog_timer_with_postscaler
  import wdt_pkg::*;
;
  logic        sys_clk_i, rstn_i, awvalid_i, wvalid_i, bready_i;
  logic        arvalid_i, rready_i, awready_o, wready_o, bvalid_o;
  logic        arready_o, rvalid_o, device_reset_o, wake_o, sleeping_o;
  logic [13:0] config_word_i;
  logic [3:0]  awaddr_i, araddr_i, wstrb_i;
  logic [31:0] wdata_i, rdata_o, d;
  logic [1:0]  bresp_o, rresp_o, r;
  int          fails, checks_done, cycles;

  // A short period lets every postscaler ratio fit in a brief run.
  localparam int unsigned TB_PERIOD   = 50;
  localparam int          PULSE_LIMIT = 8000;
  localparam int          CYCLE_LIMIT = 40000;

  wdt_top #(.PERIOD_CYC(TB_PERIOD)) dut (.sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .config_word_i(config_word_i), .awvalid_i(awvalid_i),
    .awready_o(awready_o), .awaddr_i(awaddr_i), .wvalid_i(wvalid_i),
    .wready_o(wready_o), .wdata_i(wdata_i), .wstrb_i(wstrb_i),
    .bvalid_o(bvalid_o), .bready_i(bready_i), .bresp_o(bresp_o),
    .arvalid_i(arvalid_i), .arready_o(arready_o), .araddr_i(araddr_i),
    .rvalid_o(rvalid_o), .rready_i(rready_i), .rdata_o(rdata_o),
    .rresp_o(rresp_o), .device_reset_o(device_reset_o),
    .wake_o(wake_o), .sleeping_o(sleeping_o));

  // --------------------------------------------------------------------
  // Bus tasks
  // --------------------------------------------------------------------
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Ready is sampled mid-cycle, where it is settled for the coming edge.
  task axi_write(input logic [3:0] a, input logic [31:0] v);
    logic ta, tw, aw_done, w_done;
    aw_done = 1'b0;
    w_done  = 1'b0;
    @(posedge sys_clk_i);
    awvalid_i <= 1'b1;
    awaddr_i  <= a;
    wvalid_i  <= 1'b1;
    wdata_i   <= v;
    do
    begin
      @(negedge sys_clk_i);
      ta = !aw_done && (awready_o === 1'b1);
      tw = !w_done && (wready_o === 1'b1);
      @(posedge sys_clk_i);
      if (ta)
      begin
        awvalid_i <= 1'b0;
        aw_done = 1'b1;
      end
      if (tw)
      begin
        wvalid_i <= 1'b0;
        w_done = 1'b1;
      end
    end while (!(aw_done && w_done));
    bready_i <= 1'b1;
    do
    begin
      @(negedge sys_clk_i);
      ta = bvalid_o;
      r = bresp_o;
      @(posedge sys_clk_i);
    end while (!ta);
    bready_i <= 1'b0;
  endtask : axi_write

  task axi_read(input logic [3:0] a);
    logic g;
    @(posedge sys_clk_i);
    arvalid_i <= 1'b1; araddr_i <= a;
    do
    begin
      @(negedge sys_clk_i);
      g = arready_o;
      @(posedge sys_clk_i);
    end while (!g);
    arvalid_i <= 1'b0; rready_i <= 1'b1;
    do
    begin
      @(negedge sys_clk_i);
      g = rvalid_o; d = rdata_o; r = rresp_o;
      @(posedge sys_clk_i);
    end while (!g);
    rready_i <= 1'b0;
  endtask : axi_read

  task do_reset(input logic [13:0] cw);
    rstn_i <= 1'b0; config_word_i <= cw;
    repeat (2) @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    repeat (6) @(posedge sys_clk_i);
  endtask : do_reset

  // Counts falling edges until an expiry effect shows, or the limit.
  task wait_pulse(output int n);
    n = 0;
    do
    begin
      @(negedge sys_clk_i);
      n++;
    end while (device_reset_o !== 1'b1 && wake_o !== 1'b1 &&
               n < PULSE_LIMIT);
  endtask : wait_pulse

  // --------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------
  task t_fuse_off;
    int n;
    do_reset(14'h3FFB);
    axi_read(CONFIG_ADDR); check(d, 32'h0000_0000);
    wait_pulse(n);
    check(32'(n), 32'(PULSE_LIMIT));
  endtask : t_fuse_off

  task t_reset_vals;
    do_reset(14'h3FFF);
    axi_read(OPTION_ADDR); check(d, {24'h0, OPTION_RST});
    axi_read(STATUS_ADDR); check(d, 32'h0000_0001);
    axi_read(CONFIG_ADDR); check(d, 32'h0000_0001);
  endtask : t_reset_vals

  // Every ratio, both assignments, with the upper option bits held at hex A.
  task t_option;
    logic [31:0] v;
    for (int i = 0; i < 16; i++)
    begin
      v = {24'h0, 4'hA, 4'(i)};
      axi_write(OPTION_ADDR, v); check(32'(r), 32'(RESP_OKAY));
      axi_read(OPTION_ADDR); check(d, v);
    end
  endtask : t_option

  // A clear comes first, since earlier expiries have cleared the flag.
  task t_read_only;
    axi_write(CONTROL_ADDR, 32'h1); check(32'(r), 32'(RESP_OKAY));
    axi_write(STATUS_ADDR, 32'h0); check(32'(r), 32'(RESP_SLVERR));
    axi_read(STATUS_ADDR); check(d, 32'h0000_0001);
    axi_write(CONFIG_ADDR, 32'h0); check(32'(r), 32'(RESP_SLVERR));
    axi_read(CONFIG_ADDR); check(d, 32'h0000_0001);
    check(32'(r), 32'(RESP_OKAY));
    axi_read(4'h2); check(32'(r), 32'(RESP_SLVERR));
    check(d, 32'h0000_0000);
  endtask : t_read_only

  // Expiry spacing, unscaled and through every postscaler ratio.
  task t_expire;
    int n;
    axi_write(OPTION_ADDR, 32'h0);
    axi_write(CONTROL_ADDR, 32'h1);
    wait_pulse(n);
    check(32'(n), 32'(TB_PERIOD + 2));
    check({31'h0, device_reset_o}, 32'h0000_0001);
    check({31'h0, wake_o}, 32'h0000_0000);
    wait_pulse(n);
    check(32'(n), 32'(TB_PERIOD));
    axi_read(STATUS_ADDR);
    check(d, 32'h0000_0000);
    for (int i = 0; i < 8; i++)
    begin
      axi_write(OPTION_ADDR, 32'(8 + i));
      axi_write(CONTROL_ADDR, 32'h1);
      wait_pulse(n);
      check(32'(n), 32'((TB_PERIOD << i) + 2));
    end
  endtask : t_expire

  // Sleep ends only through an expiry, which wakes instead of resetting.
  task t_sleep;
    int n;
    axi_write(OPTION_ADDR, 32'h0); check(32'(r), 32'(RESP_OKAY));
    axi_write(CONTROL_ADDR, 32'h1); check(32'(r), 32'(RESP_OKAY));
    check({31'h0, sleeping_o}, 32'h0000_0000);
    axi_write(CONTROL_ADDR, 32'h2); check(32'(r), 32'(RESP_OKAY));
    axi_read(STATUS_ADDR); check(d, 32'h0000_0003);
    check({31'h0, device_reset_o}, 32'h0000_0000);
    axi_write(CONTROL_ADDR, 32'h2);
    wait_pulse(n);
    check(32'(n), 32'(TB_PERIOD + 2));
    check({31'h0, wake_o}, 32'h0000_0001);
    check({31'h0, device_reset_o}, 32'h0000_0000);
    check({31'h0, sleeping_o}, 32'h0000_0000);
    axi_read(STATUS_ADDR);
    check(d, 32'h0000_0000);
  endtask : t_sleep

  task finish_test;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : finish_test

  // --------------------------------------------------------------------
  // Clock, timeout and main sequence
  // --------------------------------------------------------------------
  initial
  begin
    sys_clk_i = 1'b0;
    forever #25 sys_clk_i = ~sys_clk_i;
  end

  always @(posedge sys_clk_i)
  begin
    cycles++;
    if (cycles == CYCLE_LIMIT)
    begin
      fails++;
      finish_test();
    end
  end

  initial
  begin
    rstn_i = 1'b0; config_word_i = 14'h3FFF; awvalid_i = 1'b0;
    wvalid_i = 1'b0; bready_i = 1'b0; arvalid_i = 1'b0; rready_i = 1'b0;
    awaddr_i = 4'h0; araddr_i = 4'h0; wstrb_i = 4'hF; wdata_i = 32'h0;
    t_fuse_off();
    t_reset_vals();
    t_option();
    t_read_only();
    t_expire();
    t_sleep();
    finish_test();
  end
endmodule : tb_watchdog_timer_with_postscaler

bind wdt_top wdt_top_checker u_chk (.sys_clk_i(sys_clk_i),
  .rstn_i(rstn_i), .config_word_i(config_word_i), .arvalid_i(arvalid_i),
  .arready_o(arready_o), .rvalid_o(rvalid_o), .rready_i(rready_i),
  .rdata_o(rdata_o), .bvalid_o(bvalid_o), .bready_i(bready_i),
  .device_reset_o(device_reset_o), .wake_o(wake_o),
  .sleeping_o(sleeping_o));
